// File: pwa_far_side_model.sv
// far-side model: comparator pins and pulse generator triggers
`timescale 1ns/100ps
module pwa_far_side_model
   import pwa_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic trigRun,
   input wire logic [3:0] trigGap,
   input wire logic ovLevel,
   input wire logic revLevel,
   output logic overloadCmpIn = OV_CMP_RST,
   output logic reverseVoltCmpIn = REV_CMP_RST,
   output logic pulseTrig = 1'b0
);
   logic [3:0] gapCnt = 4'h0;
   // ----------------------------------------------------------------
   // pins change on the falling edge, away from the sampling edge
   // ----------------------------------------------------------------
   always @(negedge sys_clk) begin
      if (!rst_n) begin
         pulseTrig <= 1'b0;
         gapCnt <= 4'h0;
      end else begin
         overloadCmpIn <= ovLevel;
         reverseVoltCmpIn <= revLevel;
         // one-cycle trigger, gap of at least two keeps pulses apart
         pulseTrig <= trigRun && (gapCnt == 4'h0);
         gapCnt <= (gapCnt >= trigGap - 4'h1) ? 4'h0 : gapCnt + 4'h1;
      end
   end
endmodule : pwa_far_side_model

// File: pwa_pkg.sv
// package: constants, types and lookups of the pulse width approach controller
package pwa_pkg;
   localparam int WIDTH_W = 9;
   localparam int TIMER_W = 8;
   // ----------------------------------------------------------------
   // phase codes and limits
   // ----------------------------------------------------------------
   localparam logic [1:0] PHASE_FIRST = 2'h0;
   localparam logic [1:0] PHASE_TO_FIRST = 2'h1;
   localparam logic [1:0] PHASE_TO_SECOND = 2'h2;
   localparam logic [1:0] PHASE_IDLE = 2'h3;
   localparam logic [WIDTH_W-1:0] WIDTH_MAX = 9'h1FF;
   localparam logic [WIDTH_W-1:0] WIDTH_MIN = 9'h000;
   localparam logic [WIDTH_W-1:0] WIDTH_RST = 9'h000;
   localparam logic [TIMER_W-1:0] TIMER_TOP = 8'hFF;
   localparam logic [TIMER_W-1:0] TIMER_RST = 8'h00;
   localparam logic [1:0] TRIG_FIELD_RST = 2'h0;
   localparam logic [1:0] TRIG_FIELD_MAX = 2'h3;
   localparam logic [2:0] STEP_FIELD_RST = 3'h0;
   localparam logic [2:0] STEP_FIELD_MAX = 3'h7;
   localparam logic [1:0] ADJ_NONE = 2'h0;
   localparam logic [1:0] ADJ_DEC = 2'h1;
   localparam logic [1:0] ADJ_INC = 2'h2;
   localparam logic OV_CMP_RST = 1'b0;
   localparam logic REV_CMP_RST = 1'b1;
   // prescaler masks for divide by 1, 2, 4, 8
   localparam logic [3:0][2:0] PSC_MASK = {3'h7, 3'h3, 3'h1, 3'h0};
   localparam logic [2:0] PSC_RST = 3'h0;
   localparam logic [2:0] CNT3_RST = 3'h0;
   localparam logic [3:0] CNT4_RST = 4'h0;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_FIRST = 4'h2,
      ST_TO_FIRST = 4'h4,
      ST_TO_SECOND = 4'h8
   } pwa_state_e;
   typedef struct packed {
      logic [WIDTH_W-1:0] firstTarget;
      logic [WIDTH_W-1:0] secondTarget;
      logic [TIMER_W-1:0] firstReload;
      logic [TIMER_W-1:0] secondReload;
      logic [TIMER_W-1:0] thirdReload;
      logic [1:0] timerClkSel;
      logic [2:0] approachThresh;
      logic [1:0] trigAdjust;
      logic [1:0] stepAdjust;
   } pwa_cfg_s;
   // ----------------------------------------------------------------
   // field lookups, swap these to change encodings
   // ----------------------------------------------------------------
   function automatic logic [2:0] pwa_trig_count(input logic [1:0] f);
      return {1'b0, f} + 3'h1;
   endfunction : pwa_trig_count
   function automatic logic [3:0] pwa_step(input logic [2:0] f);
      return {1'b0, f} + 4'h1;
   endfunction : pwa_step
   function automatic logic [3:0] pwa_thresh(input logic [2:0] f);
      return {1'b0, f} + 4'h1;
   endfunction : pwa_thresh
endpackage : pwa_pkg

// File: pwa_pulse_width_approach_ctrl.sv
// module: pulse width approach controller with three-phase interval timer
`timescale 1ns/100ps
module pwa_pulse_width_approach_ctrl
   import pwa_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic overloadCmpIn,
   input wire logic reverseVoltCmpIn,
   input wire logic pulseTrig,
   input wire pwa_cfg_s cfg,
   input wire logic hwModeSel,
   input wire logic startSrcSel,
   input wire logic targetSel,
   input wire logic approachEnWr,
   input wire logic approachEnWrData,
   input wire logic timerRunWr,
   input wire logic timerRunWrData,
   input wire logic widthWr,
   input wire logic [WIDTH_W-1:0] widthWrData,
   input wire logic fieldWr,
   input wire logic [1:0] trigCountWrData,
   input wire logic [2:0] stepSizeWrData,
   input wire logic firstReachedClr,
   input wire logic secondReachedClr,
   input wire logic masterIrqEn,
   input wire logic doneIrqEn,
   input wire logic mfIrqEn,
   output logic [WIDTH_W-1:0] widthValue,
   output logic [1:0] trigCountField,
   output logic [2:0] stepSizeField,
   output logic [1:0] phaseField,
   output logic approachEnable,
   output logic adjustActive,
   output logic firstReached,
   output logic secondReached,
   output logic timerRun,
   output logic revProtActive,
   output logic approachDoneIrq,
   output logic timerOvfIrq
);
   // ----------------------------------------------------------------
   // pin synchronisers, a change counts once stages two and three agree
   // ----------------------------------------------------------------
   logic ovS1Reg, ovS2Reg, ovS3Reg, ovFiltReg, ovPrevReg;
   logic rvS1Reg, rvS2Reg, rvS3Reg, rvFiltReg;
   logic ovFiltNext, rvFiltNext, ovRise;
   always_comb begin
      ovFiltNext = (ovS2Reg == ovS3Reg) ? ovS3Reg : ovFiltReg;
      rvFiltNext = (rvS2Reg == rvS3Reg) ? rvS3Reg : rvFiltReg;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovS1Reg <= OV_CMP_RST;
         ovS2Reg <= OV_CMP_RST;
         ovS3Reg <= OV_CMP_RST;
         ovFiltReg <= OV_CMP_RST;
         ovPrevReg <= OV_CMP_RST;
         rvS1Reg <= REV_CMP_RST;
         rvS2Reg <= REV_CMP_RST;
         rvS3Reg <= REV_CMP_RST;
         rvFiltReg <= REV_CMP_RST;
      end else if (clkEn) begin
         ovS1Reg <= overloadCmpIn;
         ovS2Reg <= ovS1Reg;
         ovS3Reg <= ovS2Reg;
         ovFiltReg <= ovFiltNext;
         ovPrevReg <= ovFiltReg;
         rvS1Reg <= reverseVoltCmpIn;
         rvS2Reg <= rvS1Reg;
         rvS3Reg <= rvS2Reg;
         rvFiltReg <= rvFiltNext;
      end
   end
   assign ovRise = ovFiltReg & ~ovPrevReg;
   // ----------------------------------------------------------------
   // sequencer, timer and approach datapath
   // ----------------------------------------------------------------
   pwa_state_e stateReg, stateNext;
   logic [TIMER_W-1:0] timerReg, timerNext;
   logic [2:0] pscReg, pscNext, trigCntReg, trigCntNext;
   logic [3:0] evtCntReg, evtCntNext;
   logic [WIDTH_W-1:0] widthReg, widthNext, target;
   logic [1:0] trigFieldReg, trigFieldNext, phaseReg, phaseNext;
   logic [2:0] stepFieldReg, stepFieldNext;
   logic runReg, runNext, enReg, enNext, adjReg, adjNext, doneReg, doneNext;
   logic overReg, overNext, firstReg, firstNext, secondReg, secondNext;
   logic hwPrevReg, irqReg, irqNext, tmrIrqReg, tmrIrqNext;
   logic runRise, hwRise, startEvt, tick, timerOvf, inApproach, approaching, locked, atTarget;
   logic setFirst, setSecond, stepNow;
   logic [WIDTH_W:0] sum;
   logic [3:0] step;
   always_comb begin
      stateNext = stateReg;
      timerNext = timerReg;
      pscNext = pscReg + 3'h1;
      trigCntNext = trigCntReg;
      evtCntNext = evtCntReg;
      widthNext = widthReg;
      trigFieldNext = trigFieldReg;
      stepFieldNext = stepFieldReg;
      runNext = runReg;
      enNext = enReg;
      adjNext = adjReg;
      doneNext = doneReg;
      overNext = overReg;
      sum = {1'b0, WIDTH_MIN};
      step = pwa_step(stepFieldReg);
      stepNow = 1'b0;
      runRise = timerRunWr & timerRunWrData & ~runReg;
      hwRise = hwModeSel & ~hwPrevReg;
      startEvt = startSrcSel ? runRise : ovRise;
      tick = ((pscReg & PSC_MASK[cfg.timerClkSel]) == PSC_RST) & runReg;
      timerOvf = tick & (timerReg == TIMER_TOP);
      inApproach = hwModeSel ? (stateReg == ST_TO_FIRST || stateReg == ST_TO_SECOND) : enReg;
      locked = inApproach;
      target = hwModeSel ? ((stateReg == ST_TO_SECOND) ? cfg.secondTarget : cfg.firstTarget)
                         : (targetSel ? cfg.secondTarget : cfg.firstTarget);
      atTarget = (widthReg == target);
      approaching = inApproach & rvFiltReg & ~doneReg;
      setFirst = approaching & atTarget & (target == cfg.firstTarget) &
                 (hwModeSel ? stateReg == ST_TO_FIRST : !targetSel);
      setSecond = approaching & atTarget & (target == cfg.secondTarget) &
                  (hwModeSel ? stateReg == ST_TO_SECOND : targetSel);
      doneNext = doneReg | (approaching & atTarget);
      // software access; width and field writes blocked while in an approach phase
      runNext = timerRunWr ? timerRunWrData : runReg;
      if (widthWr && !locked) begin
         widthNext = widthWrData;
      end
      if (fieldWr && !locked) begin
         trigFieldNext = trigCountWrData;
         stepFieldNext = stepSizeWrData;
      end
      if (!hwModeSel && approachEnWr) begin
         enNext = approachEnWrData;
      end
      if (!hwModeSel) begin
         adjNext = enNext;
         if (runRise) begin
            timerNext = cfg.firstReload;
         end
      end
      // every pwa_trig_count-th qualifying trigger steps the width value
      if (pulseTrig && approaching && !atTarget) begin
         trigCntNext = trigCntReg + 3'h1;
         if (trigCntNext >= pwa_trig_count(trigFieldReg)) begin
            trigCntNext = CNT3_RST;
            stepNow = 1'b1;
         end
      end
      if (stepNow) begin
         if (overReg) begin
            widthNext = target;
            overNext = 1'b0;
         end else if (widthReg < target) begin
            sum = {1'b0, widthReg} + {6'h00, step};
            widthNext = sum[WIDTH_W] ? WIDTH_MAX : sum[WIDTH_W-1:0];
            overNext = (widthNext > target);
         end else begin
            widthNext = ({5'h00, step} > widthReg) ? WIDTH_MIN : widthReg - {5'h00, step};
            overNext = (widthNext < target);
         end
         evtCntNext = evtCntReg + 4'h1;
         if (evtCntNext >= pwa_thresh(cfg.approachThresh)) begin
            evtCntNext = CNT4_RST;
            if (cfg.trigAdjust == ADJ_INC && trigFieldReg != TRIG_FIELD_MAX) begin
               trigFieldNext = trigFieldReg + 2'h1;
            end else if (cfg.trigAdjust == ADJ_DEC && trigFieldReg != TRIG_FIELD_RST) begin
               trigFieldNext = trigFieldReg - 2'h1;
            end
            if (cfg.stepAdjust == ADJ_INC && stepFieldReg != STEP_FIELD_MAX) begin
               stepFieldNext = stepFieldReg + 3'h1;
            end else if (cfg.stepAdjust == ADJ_DEC && stepFieldReg != STEP_FIELD_RST) begin
               stepFieldNext = stepFieldReg - 3'h1;
            end
         end
      end
      if (tick) begin
         timerNext = (timerOvf && !hwModeSel) ? cfg.firstReload : timerReg + 8'h01;
      end
      // interval sequencer
      case (stateReg)
         ST_IDLE: begin
            if (hwModeSel && !hwRise && startEvt) begin
               stateNext = ST_FIRST;
               timerNext = cfg.firstReload;
               runNext = 1'b1;
            end
         end
         ST_FIRST: begin
            if (timerOvf) begin
               stateNext = ST_TO_FIRST;
               timerNext = cfg.secondReload;
               enNext = 1'b1;
               adjNext = 1'b1;
            end
         end
         ST_TO_FIRST: begin
            if (timerOvf) begin
               stateNext = ST_TO_SECOND;
               timerNext = cfg.thirdReload;
            end
         end
         ST_TO_SECOND: begin
            if (timerOvf) begin
               stateNext = ST_IDLE;
               runNext = 1'b0;
               enNext = 1'b0;
               adjNext = 1'b0;
            end
         end
         default: stateNext = ST_IDLE;
      endcase
      if (stateNext != stateReg) begin
         doneNext = 1'b0;
         overNext = 1'b0;
         trigCntNext = CNT3_RST;
      end
      if (!hwModeSel || hwRise) begin
         stateNext = ST_IDLE;
      end
      // a leftover software enable must not show in phases 00 and 11
      if (hwRise) begin
         runNext = 1'b0;
         enNext = 1'b0;
         adjNext = 1'b0;
      end
      // set wins over either clear
      firstNext = setFirst | (firstReg & ~firstReachedClr & ~(ovRise | runRise));
      secondNext = setSecond | (secondReg & ~secondReachedClr & ~(ovRise | runRise));
      irqNext = (setFirst | setSecond) & masterIrqEn & doneIrqEn & mfIrqEn;
      tmrIrqNext = timerOvf & ~hwModeSel;
      case (stateNext)
         ST_FIRST: phaseNext = PHASE_FIRST;
         ST_TO_FIRST: phaseNext = PHASE_TO_FIRST;
         ST_TO_SECOND: phaseNext = PHASE_TO_SECOND;
         default: phaseNext = PHASE_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stateReg <= ST_IDLE;
         timerReg <= TIMER_RST;
         pscReg <= PSC_RST;
         trigCntReg <= CNT3_RST;
         evtCntReg <= CNT4_RST;
         widthReg <= WIDTH_RST;
         trigFieldReg <= TRIG_FIELD_RST;
         stepFieldReg <= STEP_FIELD_RST;
         phaseReg <= PHASE_IDLE;
         runReg <= 1'b0;
         enReg <= 1'b0;
         adjReg <= 1'b0;
         doneReg <= 1'b0;
         overReg <= 1'b0;
         firstReg <= 1'b0;
         secondReg <= 1'b0;
         hwPrevReg <= 1'b0;
         irqReg <= 1'b0;
         tmrIrqReg <= 1'b0;
      end else if (clkEn) begin
         stateReg <= stateNext;
         timerReg <= timerNext;
         pscReg <= pscNext;
         trigCntReg <= trigCntNext;
         evtCntReg <= evtCntNext;
         widthReg <= widthNext;
         trigFieldReg <= trigFieldNext;
         stepFieldReg <= stepFieldNext;
         phaseReg <= phaseNext;
         runReg <= runNext;
         enReg <= enNext;
         adjReg <= adjNext;
         doneReg <= doneNext;
         overReg <= overNext;
         firstReg <= firstNext;
         secondReg <= secondNext;
         hwPrevReg <= hwModeSel;
         irqReg <= irqNext;
         tmrIrqReg <= tmrIrqNext;
      end
   end
   assign widthValue = widthReg;
   assign trigCountField = trigFieldReg;
   assign stepSizeField = stepFieldReg;
   assign phaseField = phaseReg;
   assign approachEnable = enReg;
   assign adjustActive = adjReg;
   assign firstReached = firstReg;
   assign secondReached = secondReg;
   assign timerRun = runReg;
   assign revProtActive = ~rvFiltReg;
   assign approachDoneIrq = irqReg & clkEn;
   assign timerOvfIrq = tmrIrqReg & clkEn;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_first_frozen;
      (clkEn && stateReg == ST_FIRST && !widthWr) |=> (widthReg == $past(widthReg));
   endproperty
   a_first_frozen: assert property (p_first_frozen) else $error("width moved in first interval");
   property p_lock;
      (clkEn && locked && widthWr && !pulseTrig) |=> (widthReg == $past(widthReg));
   endproperty
   a_lock: assert property (p_lock) else $error("locked width was written");
   property p_end_idle;
      (clkEn && hwModeSel && stateReg == ST_TO_SECOND && timerOvf) |=> (phaseReg == PHASE_IDLE && !runReg && !enReg && !adjReg);
   endproperty
   a_end_idle: assert property (p_end_idle) else $error("third interval end not idle");
   property p_hw_enable;
      (stateReg == ST_TO_FIRST || stateReg == ST_TO_SECOND) |-> (enReg && phaseReg != PHASE_IDLE);
   endproperty
   a_hw_enable: assert property (p_hw_enable) else $error("approach enable low in approach phase");
   property p_hw_clears_run;
      (clkEn && hwModeSel && !hwPrevReg) |=> !runReg;
   endproperty
   a_hw_clears_run: assert property (p_hw_clears_run) else $error("run bit survived hardware mode entry");
   property p_flag_clear;
      (clkEn && (ovRise || runRise) && !setFirst) |=> !firstReg;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("first flag not cleared at start");
   property p_sw_disabled;
      (clkEn && !hwModeSel && !enReg && !approachEnWr && !widthWr) |=> (widthReg == $past(widthReg));
   endproperty
   a_sw_disabled: assert property (p_sw_disabled) else $error("width moved while disabled");
   property p_rev_hold;
      (clkEn && !rvFiltReg && !widthWr) |=> (widthReg == $past(widthReg));
   endproperty
   a_rev_hold: assert property (p_rev_hold) else $error("width stepped under reverse voltage");
   property p_irq_gate;
      approachDoneIrq |-> $past(masterIrqEn && doneIrqEn && mfIrqEn);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("done irq without all enables");
endmodule : pwa_pulse_width_approach_ctrl

// File: pwa_pulse_width_approach_ctrl_bench.sv
// testbench: pulse width approach controller against the far-side model
`timescale 1ns/100ps
module pwa_pulse_width_approach_ctrl_bench;
   import pwa_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, hwModeSel = 1'b0, startSrcSel = 1'b0;
   logic targetSel = 1'b0, approachEnWr = 1'b0, approachEnWrData = 1'b0, timerRunWr = 1'b0;
   logic timerRunWrData = 1'b0, widthWr = 1'b0, fieldWr = 1'b0, firstReachedClr = 1'b0;
   logic secondReachedClr = 1'b0, masterIrqEn = 1'b1, doneIrqEn = 1'b1, mfIrqEn = 1'b1;
   logic [WIDTH_W-1:0] widthWrData = 9'h000;
   logic [1:0] trigCountWrData = 2'h0;
   logic [2:0] stepSizeWrData = 3'h0;
   logic trigRun = 1'b0, ovLevel = 1'b0, revLevel = 1'b1;
   logic [3:0] trigGap = 4'h2;
   pwa_cfg_s cfg;
   logic overloadCmpIn, reverseVoltCmpIn, pulseTrig, approachEnable, adjustActive, firstReached;
   logic secondReached, timerRun, revProtActive, approachDoneIrq, timerOvfIrq;
   logic [WIDTH_W-1:0] widthValue;
   logic [1:0] trigCountField, phaseField;
   logic [2:0] stepSizeField;
   logic [8:0] widthQ[$], phaseQ[$];
   logic [8:0] lastWidth = 9'h000, wExp;
   logic [1:0] lastPhase = 2'h3;
   int errors = 0, comparisons = 0, doneIrqs = 0, ovfIrqs = 0, n;

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   pwa_far_side_model u_pwa_far_side_model (.sys_clk(sys_clk), .rst_n(rst_n), .trigRun(trigRun),
      .trigGap(trigGap), .ovLevel(ovLevel), .revLevel(revLevel), .overloadCmpIn(overloadCmpIn),
      .reverseVoltCmpIn(reverseVoltCmpIn), .pulseTrig(pulseTrig));

   pwa_pulse_width_approach_ctrl u_pwa_pulse_width_approach_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
      .clkEn(clkEn), .overloadCmpIn(overloadCmpIn), .reverseVoltCmpIn(reverseVoltCmpIn),
      .pulseTrig(pulseTrig), .cfg(cfg), .hwModeSel(hwModeSel), .startSrcSel(startSrcSel),
      .targetSel(targetSel), .approachEnWr(approachEnWr), .approachEnWrData(approachEnWrData),
      .timerRunWr(timerRunWr), .timerRunWrData(timerRunWrData), .widthWr(widthWr),
      .widthWrData(widthWrData), .fieldWr(fieldWr), .trigCountWrData(trigCountWrData),
      .stepSizeWrData(stepSizeWrData), .firstReachedClr(firstReachedClr),
      .secondReachedClr(secondReachedClr), .masterIrqEn(masterIrqEn), .doneIrqEn(doneIrqEn),
      .mfIrqEn(mfIrqEn), .widthValue(widthValue), .trigCountField(trigCountField),
      .stepSizeField(stepSizeField), .phaseField(phaseField), .approachEnable(approachEnable),
      .adjustActive(adjustActive), .firstReached(firstReached), .secondReached(secondReached),
      .timerRun(timerRun), .revProtActive(revProtActive), .approachDoneIrq(approachDoneIrq),
      .timerOvfIrq(timerOvfIrq));

   // ----------------------------------------------------------------
   // checking and reporting
   // ----------------------------------------------------------------
   task automatic compare(input logic [8:0] got, input logic [8:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s: got %0d expected %0d", $time, what, got, exp);
      end
   endtask : compare

   task automatic final_report;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // any change of width or phase must match the oldest note; an empty queue forces a mismatch
   always @(negedge sys_clk) begin
      if (rst_n) begin
         if (widthValue !== lastWidth) begin
            wExp = (widthQ.size() > 0) ? widthQ.pop_front() : ~widthValue;
            compare(widthValue, wExp, "width change");
         end
         if (phaseField !== lastPhase) begin
            wExp = (phaseQ.size() > 0) ? phaseQ.pop_front() : 9'h1FF;
            compare({7'h0, phaseField}, wExp, "phase change");
         end
         lastWidth <= widthValue;
         lastPhase <= phaseField;
         if (approachDoneIrq === 1'b1) doneIrqs++;
         if (timerOvfIrq === 1'b1) ovfIrqs++;
      end
   end

   // ----------------------------------------------------------------
   // drivers, entered at a falling edge
   // ----------------------------------------------------------------
   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask : cyc

   // kind: 0 width, 1 fields, 2 enable, 3 run bit, 4 clear first, 5 clear second
   task automatic soft_wr(input int kind, input logic [8:0] d);
      widthWrData = d;
      trigCountWrData = d[1:0];
      stepSizeWrData = d[4:2];
      approachEnWrData = d[0];
      timerRunWrData = d[0];
      widthWr = (kind == 0);
      fieldWr = (kind == 1);
      approachEnWr = (kind == 2);
      timerRunWr = (kind == 3);
      firstReachedClr = (kind == 4);
      secondReachedClr = (kind == 5);
      cyc(1);
      {widthWr, fieldWr, approachEnWr, timerRunWr, firstReachedClr, secondReachedClr} = 6'h00;
      cyc(1);
   endtask : soft_wr

   task automatic wait_phase(input logic [1:0] ph, output int k);
      k = 0;
      while (phaseField !== ph && k < 2000) begin
         cyc(1);
         k++;
      end
      compare({7'h0, phaseField}, {7'h0, ph}, "phase reached");
   endtask : wait_phase

   initial begin
      cfg = '{firstTarget: 9'h1A4, secondTarget: 9'h19A, firstReload: 8'hF0, secondReload: 8'h00,
         thirdReload: 8'h00, timerClkSel: 2'h1, approachThresh: 3'h1, trigAdjust: ADJ_INC,
         stepAdjust: ADJ_NONE};
      void'($urandom(24282));
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      cyc(2);
      // hardware sequence: 400 up to 420, then down to 410 with an overshoot
      widthQ.push_back(9'h190);
      soft_wr(0, 9'h190);
      soft_wr(1, {4'h0, 3'h3, 2'h2});
      compare({7'h0, trigCountField}, 9'h002, "field write");
      soft_wr(3, 9'h001);
      hwModeSel = 1'b1;
      cyc(3);
      compare({8'h0, timerRun}, 9'h000, "run cleared on hw entry");
      widthQ.delete();
      widthQ = '{9'h194, 9'h198, 9'h19C, 9'h1A0, 9'h1A4, 9'h1A0, 9'h19C, 9'h198, 9'h19A};
      phaseQ = '{9'h000, 9'h001, 9'h002, 9'h003};
      trigRun = 1'b1;
      ovLevel = 1'b1;
      wait_phase(PHASE_FIRST, n);
      wait_phase(PHASE_TO_FIRST, n);
      compare({8'h0, (n >= 28 && n <= 36)}, 9'h001, "first interval length");
      compare(widthValue, 9'h190, "width frozen in first interval");
      compare({8'h0, approachEnable}, 9'h001, "hw enable");
      soft_wr(0, 9'($urandom_range(255)));
      soft_wr(1, 9'($urandom_range(31)));
      wait_phase(PHASE_TO_SECOND, n);
      compare({7'h0, firstReached, secondReached}, 9'h002, "first flag");
      wait_phase(PHASE_IDLE, n);
      cyc(2);
      compare({7'h0, secondReached, timerRun}, 9'h002, "idle flags");
      compare({7'h0, approachEnable, adjustActive}, 9'h000, "idle enables");
      compare({4'h0, stepSizeField, trigCountField}, 9'h00F, "fields adjusted");
      compare(9'(doneIrqs), 9'h002, "done irq count");
      compare(9'(widthQ.size()), 9'h000, "hw steps all seen");
      soft_wr(4, 9'h000);
      compare({7'h0, firstReached, secondReached}, 9'h001, "first flag cleared");
      soft_wr(5, 9'h000);
      compare({8'h0, secondReached}, 9'h000, "second flag cleared");
      $display("test hardware sequence finished");
      // software mode: suspend on reverse voltage, then saturate at the top
      hwModeSel = 1'b0;
      ovLevel = 1'b0;
      mfIrqEn = 1'b0;
      revLevel = 1'b0;
      trigGap = 4'($urandom_range(5, 2));
      cfg.secondTarget = 9'h1FF;
      targetSel = 1'b1;
      widthQ.push_back(9'h1FC);
      soft_wr(0, 9'h1FC);
      soft_wr(1, {4'h0, 3'h7, 2'h0});
      cyc(8);
      compare({8'h0, revProtActive}, 9'h001, "reverse voltage seen");
      soft_wr(2, 9'h001);
      cyc(30);
      compare({7'h0, approachEnable, adjustActive}, 9'h003, "sw enable");
      widthQ.push_back(9'h1FF);
      revLevel = 1'b1;
      cyc(30);
      compare({7'h0, secondReached, revProtActive}, 9'h002, "sw second flag");
      compare(9'(doneIrqs), 9'h002, "masked done irq");
      soft_wr(2, 9'h000);
      soft_wr(3, 9'h001);
      cyc(2);
      compare({8'h0, secondReached}, 9'h000, "run rise clears flag");
      // an unfrozen timer would overflow inside this span
      clkEn = 1'b0;
      cyc(40);
      compare(9'(ovfIrqs), 9'h000, "timer frozen by clock enable");
      clkEn = 1'b1;
      cyc(40);
      compare(9'(ovfIrqs), 9'h001, "sw timer overflow");
      compare(9'(widthQ.size()), 9'h000, "sw steps all seen");
      $display("test software mode finished");
      // hardware sequence started by the run bit; reverse voltage keeps the width still
      revLevel = 1'b0;
      startSrcSel = 1'b1;
      hwModeSel = 1'b1;
      cyc(8);
      phaseQ = '{9'h000, 9'h001, 9'h002, 9'h003};
      soft_wr(3, 9'h001);
      wait_phase(PHASE_TO_SECOND, n);
      wait_phase(PHASE_IDLE, n);
      cyc(2);
      compare(9'(phaseQ.size()), 9'h000, "run-bit start phases");
      compare(widthValue, 9'h1FF, "width held under reverse voltage");
      compare({7'h0, approachEnable, timerRun}, 9'h000, "second idle");
      $display("test run-bit start finished");
      final_report();
   end

   initial begin
      #(4 * 5000);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end
endmodule : pwa_pulse_width_approach_ctrl_bench
